/* include/tmra_pkg.sv */
// Purpose: Shared constants and types for the register A I/O control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
package tmra_pkg;

    localparam int CNT_W = 16;
    localparam int NUM_CH = 2;
    localparam int ADDR_W = 12;
    localparam int CTRL_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CH4_IO_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_CH5_IO_CTRL = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_CH4_GRA = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_CH5_GRA = 12'h00c;
    localparam logic [ADDR_W-1:0] OFF_EVT_STATUS = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_EVT_MASK = 12'h014;
    localparam logic [ADDR_W-1:0] OFF_PIN_STATE = 12'h018;

    // Select field of register A inside the I/O control register
    localparam int SEL_BIT3 = 3;
    localparam int SEL_BIT2 = 2;
    localparam int SEL_BIT1 = 1;
    localparam int SEL_BIT0 = 0;

    // Event bits, two per channel at channel*EVT_PER_CH
    localparam int EVT_PER_CH = 2;
    localparam int EVT_CMP = 0;
    localparam int EVT_CAP = 1;
    localparam int EVT_W = NUM_CH * EVT_PER_CH;

    // Pin state bits, three per channel at channel*PIN_PER_CH
    localparam int PIN_PER_CH = 4;
    localparam int PIN_LVL = 0;
    localparam int PIN_OUT = 1;
    localparam int PIN_OE = 2;

    // Reset values
    localparam logic [CTRL_W-1:0] IO_CTRL_RST = 8'h00;
    localparam logic [CNT_W-1:0] GRA_RST = 16'hffff;
    localparam logic [EVT_W-1:0] EVT_RST = 4'h0;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    typedef enum {
        MODE_OFF,
        MODE_LOW,
        MODE_HIGH,
        MODE_TOGGLE,
        MODE_CAP_RISE,
        MODE_CAP_FALL,
        MODE_CAP_BOTH,
        MODE_CAP_CASCADE
    } tmra_mode_t;

endpackage

/* logic/tmra_pin_sync.sv */
// Purpose: Pin synchroniser with edge detection
// Assumes: Pin is asynchronous to pclk
// Notes: Edges are one-cycle pulses, two cycles after the pin moves
`timescale 1ns/1ns
module tmra_pin_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin_in,
    output logic level,
    output logic rise,
    output logic fall
);
    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;

    // First stage is read only by the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= sync2_ff;
        end
    end

    assign level = sync2_ff;
    assign rise = sync2_ff & ~prev_ff;
    assign fall = ~sync2_ff & prev_ff;

endmodule

/* logic/tmra_io_ctrl.sv */
// Purpose: Register A I/O control for timer channels 4 and 5
// Assumes: Counters and the channel 3 event come from pclk logic
// Notes: APB slave, zero wait states, read data latched in setup
//
// Overview of operation
// - Top bit clear: compare; low-drive codes
// - Codes 0x10 drive pin high on match
// - Codes 0x11 toggle pin on match
// - Code 1000 captures on rising pin edge
// - Code 1001 captures on falling pin edge
// - Codes 101x capture on both edges
// - Channel 4 codes 10xx use own pin
// - Channel 4 codes 11xx capture on channel 3
// - Channel 5 ignores bit 2 in capture
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ns
module tmra_io_ctrl
    import tmra_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tmra_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [tmra_pkg::CNT_W-1:0] ch4_count,
    input wire logic [tmra_pkg::CNT_W-1:0] ch5_count,
    input wire logic ch3_reg_a_event,
    input wire logic ch4_pin_a_in,
    output logic ch4_pin_a_out,
    output logic ch4_pin_a_oe,
    input wire logic ch5_pin_a_in,
    output logic ch5_pin_a_out,
    output logic ch5_pin_a_oe,
    output logic ch4_cmp_match,
    output logic ch4_capture,
    output logic ch5_cmp_match,
    output logic ch5_capture,
    output logic irq
);
    import tmra_pkg::*;

    // Decode of the four select bits into a mode
    function automatic tmra_mode_t decode_mode(
        input logic [3:0] sel,
        input logic is_ch4
    );
        tmra_mode_t m;
        m = MODE_OFF;
        if (!sel[SEL_BIT3]) begin
            case (sel[SEL_BIT1:SEL_BIT0])
                2'b01: m = MODE_LOW;
                2'b10: m = MODE_HIGH;
                2'b11: m = MODE_TOGGLE;
                default: m = MODE_OFF;
            endcase
        end else if (is_ch4 && sel[SEL_BIT2]) begin
            m = MODE_CAP_CASCADE;
        end else begin
            // Channel 5 never looks at bit 2 here
            case (sel[SEL_BIT1:SEL_BIT0])
                2'b00: m = MODE_CAP_RISE;
                2'b01: m = MODE_CAP_FALL;
                2'b10: m = MODE_CAP_BOTH;
                2'b11: m = MODE_CAP_BOTH;
                default: m = MODE_CAP_RISE;
            endcase
        end
        return m;
    endfunction

    // Bus phases
    logic setup_phase;
    logic wr_access;
    logic addr_hit;

    assign setup_phase = psel & ~penable;
    assign wr_access = psel & penable & pwrite;
    assign pready = 1'b1;

    // Channel-indexed views of the ports
    logic [CNT_W-1:0] count [NUM_CH];
    logic [NUM_CH-1:0] pin_in;
    logic [NUM_CH-1:0] pin_lvl;
    logic [NUM_CH-1:0] pin_rise;
    logic [NUM_CH-1:0] pin_fall;
    logic [NUM_CH-1:0] io_wr;
    logic [NUM_CH-1:0] gra_wr;
    logic [NUM_CH-1:0] cmp_evt;
    logic [NUM_CH-1:0] cap_evt;

    assign count[0] = ch4_count;
    assign count[1] = ch5_count;
    assign pin_in[0] = ch4_pin_a_in;
    assign pin_in[1] = ch5_pin_a_in;

    assign io_wr[0] = wr_access & (paddr == OFF_CH4_IO_CTRL);
    assign io_wr[1] = wr_access & (paddr == OFF_CH5_IO_CTRL);
    assign gra_wr[0] = wr_access & (paddr == OFF_CH4_GRA);
    assign gra_wr[1] = wr_access & (paddr == OFF_CH5_GRA);

    // Register state
    logic [CTRL_W-1:0] io_ctrl_ff [NUM_CH];
    logic [CNT_W-1:0] gra_ff [NUM_CH];
    logic [NUM_CH-1:0] pin_out_ff;
    logic [NUM_CH-1:0] pin_oe;
    logic [NUM_CH-1:0] eq_prev_ff;
    logic [NUM_CH-1:0] cmp_pulse_ff;
    logic [NUM_CH-1:0] cap_pulse_ff;
    logic [EVT_W-1:0] evt_status_ff;
    logic [EVT_W-1:0] evt_mask_ff;
    logic [EVT_W-1:0] evt_set;
    logic [31:0] prdata_ff;
    logic pslverr_ff;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            tmra_mode_t mode;
            tmra_mode_t new_mode;
            logic eq;
            logic match;
            logic trig;

            tmra_pin_sync u_sync (
                .pclk(pclk),
                .presetn(presetn),
                .pin_in(pin_in[ch]),
                .level(pin_lvl[ch]),
                .rise(pin_rise[ch]),
                .fall(pin_fall[ch])
            );

            assign mode = decode_mode(io_ctrl_ff[ch][3:0], ch == 0);
            assign new_mode = decode_mode(pwdata[3:0], ch == 0);

            // A counter resting on register A matches once, not every cycle
            assign eq = (count[ch] == gra_ff[ch]);
            assign match = eq & ~eq_prev_ff[ch] & ~io_ctrl_ff[ch][SEL_BIT3];

            always_comb begin
                case (mode)
                    MODE_CAP_RISE: trig = pin_rise[ch];
                    MODE_CAP_FALL: trig = pin_fall[ch];
                    MODE_CAP_BOTH: trig = pin_rise[ch] | pin_fall[ch];
                    MODE_CAP_CASCADE: trig = ch3_reg_a_event;
                    default: trig = 1'b0;
                endcase
            end

            assign cmp_evt[ch] = match;
            assign cap_evt[ch] = trig;
            assign evt_set[ch*EVT_PER_CH+EVT_CMP] = match;
            assign evt_set[ch*EVT_PER_CH+EVT_CAP] = trig;

            // Output driven only in the three active compare modes
            assign pin_oe[ch] = (mode == MODE_LOW) || (mode == MODE_HIGH) || (mode == MODE_TOGGLE);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    io_ctrl_ff[ch] <= IO_CTRL_RST;
                end else if (io_wr[ch]) begin
                    io_ctrl_ff[ch] <= pwdata[CTRL_W-1:0];
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    eq_prev_ff[ch] <= 1'b0;
                end else begin
                    eq_prev_ff[ch] <= eq;
                end
            end

            // Capture wins over a software write in the same cycle
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    gra_ff[ch] <= GRA_RST;
                end else if (trig) begin
                    gra_ff[ch] <= count[ch];
                end else if (gra_wr[ch]) begin
                    gra_ff[ch] <= pwdata[CNT_W-1:0];
                end
            end

            // Initial level is loaded when an active compare code is written
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_out_ff[ch] <= 1'b0;
                end else if (io_wr[ch]) begin
                    if (new_mode == MODE_LOW || new_mode == MODE_HIGH || new_mode == MODE_TOGGLE) begin
                        pin_out_ff[ch] <= pwdata[SEL_BIT2];
                    end
                end else if (match) begin
                    case (mode)
                        MODE_LOW: pin_out_ff[ch] <= 1'b0;
                        MODE_HIGH: pin_out_ff[ch] <= 1'b1;
                        MODE_TOGGLE: pin_out_ff[ch] <= ~pin_out_ff[ch];
                        default: pin_out_ff[ch] <= pin_out_ff[ch];
                    endcase
                end
            end
        end
    endgenerate

    // Event pulses, registered one cycle after the event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_pulse_ff <= '0;
            cap_pulse_ff <= '0;
        end else begin
            cmp_pulse_ff <= cmp_evt;
            cap_pulse_ff <= cap_evt;
        end
    end

    assign ch4_cmp_match = cmp_pulse_ff[0];
    assign ch5_cmp_match = cmp_pulse_ff[1];
    assign ch4_capture = cap_pulse_ff[0];
    assign ch5_capture = cap_pulse_ff[1];

    assign ch4_pin_a_out = pin_out_ff[0];
    assign ch5_pin_a_out = pin_out_ff[1];
    assign ch4_pin_a_oe = pin_oe[0];
    assign ch5_pin_a_oe = pin_oe[1];

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_status_ff <= EVT_RST;
        end else if (wr_access && paddr == OFF_EVT_STATUS) begin
            evt_status_ff <= (evt_status_ff & ~pwdata[EVT_W-1:0]) | evt_set;
        end else begin
            evt_status_ff <= evt_status_ff | evt_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_mask_ff <= EVT_RST;
        end else if (wr_access && paddr == OFF_EVT_MASK) begin
            evt_mask_ff <= pwdata[EVT_W-1:0];
        end
    end

    assign irq = |(evt_status_ff & evt_mask_ff);

    // Read mux
    logic [31:0] rd_word;
    logic [31:0] pin_word;

    always_comb begin
        pin_word = 32'h0000_0000;
        for (int i = 0; i < NUM_CH; i++) begin
            pin_word[i*PIN_PER_CH+PIN_LVL] = pin_lvl[i];
            pin_word[i*PIN_PER_CH+PIN_OUT] = pin_out_ff[i];
            pin_word[i*PIN_PER_CH+PIN_OE] = pin_oe[i];
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        addr_hit = 1'b1;
        case (paddr)
            OFF_CH4_IO_CTRL: rd_word[CTRL_W-1:0] = io_ctrl_ff[0];
            OFF_CH5_IO_CTRL: rd_word[CTRL_W-1:0] = io_ctrl_ff[1];
            OFF_CH4_GRA: rd_word[CNT_W-1:0] = gra_ff[0];
            OFF_CH5_GRA: rd_word[CNT_W-1:0] = gra_ff[1];
            OFF_EVT_STATUS: rd_word[EVT_W-1:0] = evt_status_ff;
            OFF_EVT_MASK: rd_word[EVT_W-1:0] = evt_mask_ff;
            OFF_PIN_STATE: rd_word = pin_word;
            default: addr_hit = 1'b0;
        endcase
    end

    // Latching in setup keeps prdata a flop output with no wait states;
    // the word reflects state one cycle before the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= RDATA_RST;
            pslverr_ff <= 1'b0;
        end else if (setup_phase) begin
            prdata_ff <= pwrite ? RDATA_RST : rd_word;
            pslverr_ff <= ~addr_hit;
        end else if (!psel) begin
            pslverr_ff <= 1'b0;
        end
    end

    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff;

endmodule

/* testbench/tmra_io_ctrl_properties.sv */
// Purpose: Port checks for the register A I/O control block
// Assumes: One pclk domain, pins looped through partner models
// Notes: Capture source checks use short input histories
`timescale 1ns/1ns
module tmra_io_ctrl_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic ch3_reg_a_event,
    input wire logic ch4_pin_a_in,
    input wire logic ch5_pin_a_in,
    input wire logic ch4_pin_a_out,
    input wire logic ch4_pin_a_oe,
    input wire logic ch4_cmp_match,
    input wire logic ch4_capture,
    input wire logic ch5_cmp_match,
    input wire logic ch5_capture,
    input wire logic irq
);
    logic [7:0] p4_ff;
    logic [7:0] p5_ff;
    logic [3:0] ev_ff;
    logic d4_ff;
    logic d5_ff;
    // Histories wider than the sync delay, so slow designs still pass
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p4_ff <= 8'h00;
            p5_ff <= 8'h00;
            ev_ff <= 4'h0;
            d4_ff <= 1'b0;
            d5_ff <= 1'b0;
        end else begin
            d4_ff <= ch4_pin_a_in;
            d5_ff <= ch5_pin_a_in;
            p4_ff <= {p4_ff[6:0], ch4_pin_a_in != d4_ff};
            p5_ff <= {p5_ff[6:0], ch5_pin_a_in != d5_ff};
            ev_ff <= {ev_ff[2:0], ch3_reg_a_event};
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_out_cause;
        $changed(ch4_pin_a_out) && $past(presetn) && !$past(psel && penable && pwrite) |-> ch4_cmp_match;
    endproperty
    a_out_cause: assert property (p_out_cause) else $error("pin changed without match");
    property p_cmp_off;
        ch4_cmp_match && !ch4_pin_a_oe |-> $stable(ch4_pin_a_out);
    endproperty
    a_cmp_off: assert property (p_cmp_off) else $error("disabled output moved");
    property p_excl;
        !(ch4_capture && ch4_cmp_match);
    endproperty
    a_excl: assert property (p_excl) else $error("capture and match together");
    property p_cap_noout;
        ch4_capture |-> !ch4_pin_a_oe;
    endproperty
    a_cap_noout: assert property (p_cap_noout) else $error("capture while driving");
    property p_src4;
        ch4_capture |-> (p4_ff != 8'h00) || (ev_ff != 4'h0);
    endproperty
    a_src4: assert property (p_src4) else $error("ch4 capture without source");
    property p_src5;
        ch5_capture |-> p5_ff != 8'h00;
    endproperty
    a_src5: assert property (p_src5) else $error("ch5 capture without pin edge");
    property p_ready;
        pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_wr_zero;
        psel && penable && pwrite |-> prdata == 32'h0000_0000;
    endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("read data on write");
    property p_irq;
        $rose(irq) |-> ch4_cmp_match || ch4_capture || ch5_cmp_match || ch5_capture || $past(pwrite);
    endproperty
    a_irq: assert property (p_irq) else $error("irq without cause");
    c_cap4: cover property (ch4_capture);
    c_cas: cover property (ch4_capture && ev_ff != 4'h0);
    c_irq: cover property ($rose(irq));
endmodule

/* testbench/tmra_pin_model.sv */
// Purpose: External timer pin
// Assumes: Pin reads the block while it drives
// Notes: Bench level shows only while the block lets go
`timescale 1ns/1ns
module tmra_pin_model (
    input wire logic drv,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_in
);
    assign pin_in = pin_oe ? pin_out : drv;
endmodule

/* testbench/tb.sv */
// Purpose: Self-checking bench for register A I/O control
// Assumes: Zero wait APB slave
// Notes: Expectations come from the select code tables
`timescale 1ns/1ns
module tb;
    import tmra_pkg::*;
    typedef struct {logic [7:0] code; logic oe; logic init; logic after;} tmra_crow_t;
    typedef struct {logic ch5; logic [7:0] code; logic p0; logic p1; logic [15:0] cnt; logic hit;} tmra_krow_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ch3_reg_a_event, drv, err, irq;
    logic ch4_pin_a_in, ch4_pin_a_out, ch4_pin_a_oe, ch5_pin_a_in, ch5_pin_a_out, ch5_pin_a_oe;
    logic ch4_cmp_match, ch4_capture, ch5_cmp_match, ch5_capture;
    logic [ADDR_W-1:0] paddr, a;
    logic [31:0] pwdata, prdata, rd;
    logic [CNT_W-1:0] ch4_count, ch5_count;
    int miscompares, checked;
    tmra_crow_t crow [8] = '{'{8'h00, 0, 0, 0}, '{8'h04, 0, 0, 0}, '{8'h01, 1, 0, 0}, '{8'h05, 1, 1, 0},
        '{8'h02, 1, 0, 1}, '{8'h06, 1, 1, 1}, '{8'h03, 1, 0, 1}, '{8'h07, 1, 1, 0}};
    tmra_krow_t krow [10] = '{'{0, 8'h08, 0, 1, 16'h0101, 1}, '{0, 8'h08, 1, 0, 16'h0102, 0},
        '{0, 8'h09, 1, 0, 16'h0103, 1}, '{0, 8'h09, 0, 1, 16'h0104, 0}, '{0, 8'h0a, 0, 1, 16'h0105, 1},
        '{0, 8'h0b, 1, 0, 16'h0106, 1}, '{0, 8'h0c, 0, 1, 16'h0107, 0}, '{1, 8'h0c, 0, 1, 16'h0108, 1},
        '{1, 8'h0d, 1, 0, 16'h0109, 1}, '{1, 8'h0e, 1, 0, 16'h010a, 1}};
    tmra_io_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .ch4_count, .ch5_count, .ch3_reg_a_event, .ch4_pin_a_in, .ch4_pin_a_out, .ch4_pin_a_oe, .ch5_pin_a_in,
        .ch5_pin_a_out, .ch5_pin_a_oe, .ch4_cmp_match, .ch4_capture, .ch5_cmp_match, .ch5_capture, .irq);
    tmra_pin_model u_p4 (.drv, .pin_out(ch4_pin_a_out), .pin_oe(ch4_pin_a_oe), .pin_in(ch4_pin_a_in));
    tmra_pin_model u_p5 (.drv, .pin_out(ch5_pin_a_out), .pin_oe(ch5_pin_a_oe), .pin_in(ch5_pin_a_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Starts on an edge so back-to-back calls never drive twice in one step
    task automatic apb(input logic w, input logic [ADDR_W-1:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic final_report;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        final_report();
    end
    initial begin
        {presetn, psel, penable, pwrite, ch3_reg_a_event, drv} = 6'h00;
        {paddr, pwdata, ch4_count, ch5_count} = '0;
        cyc(4);
        presetn <= 1'b1;
        apb(0, OFF_CH4_IO_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(0, OFF_CH4_GRA, 32'h0000_0000);
        chk(rd, 32'h0000_ffff);
        apb(1, OFF_CH4_GRA, 32'h0000_0010);
        foreach (crow[i]) begin
            apb(1, OFF_CH4_IO_CTRL, {24'h00_0000, crow[i].code});
            cyc(2);
            chk(ch4_pin_a_oe, crow[i].oe);
            if (crow[i].oe) chk(ch4_pin_a_out, crow[i].init);
            ch4_count <= 16'h0010;
            cyc(1);
            ch4_count <= 16'h0000;
            cyc(3);
            if (crow[i].oe) chk(ch4_pin_a_out, crow[i].after);
        end
        foreach (krow[i]) begin
            a = krow[i].ch5 ? OFF_CH5_IO_CTRL : OFF_CH4_IO_CTRL;
            apb(1, a, {24'h00_0000, krow[i].code});
            drv <= krow[i].p0;
            cyc(8);
            apb(1, a + 12'h008, 32'h0000_ffff);
            ch4_count <= krow[i].cnt;
            ch5_count <= krow[i].cnt;
            drv <= krow[i].p1;
            cyc(8);
            apb(0, a + 12'h008, 32'h0000_0000);
            chk(rd, krow[i].hit ? {16'h0000, krow[i].cnt} : 32'h0000_ffff);
        end
        chk(irq, 1'b0);
        apb(1, OFF_EVT_MASK, 32'h0000_0002);
        cyc(1);
        chk(irq, 1'b1);
        apb(1, OFF_EVT_STATUS, 32'h0000_000f);
        cyc(1);
        chk(irq, 1'b0);
        apb(1, OFF_CH4_GRA, 32'h0000_ffff);
        apb(1, OFF_CH5_GRA, 32'h0000_ffff);
        ch4_count <= 16'h0abc;
        ch3_reg_a_event <= 1'b1;
        cyc(1);
        ch3_reg_a_event <= 1'b0;
        cyc(1);
        chk(ch4_capture, 1'b1);
        cyc(2);
        chk(irq, 1'b1);
        apb(0, OFF_EVT_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        apb(0, OFF_CH4_GRA, 32'h0000_0000);
        chk(rd, 32'h0000_0abc);
        apb(0, OFF_CH5_GRA, 32'h0000_0000);
        chk(rd, 32'h0000_ffff);
        apb(0, 12'h020, 32'h0000_0000);
        chk(err, 1'b1);
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        chk(irq, 1'b0);
        apb(0, OFF_CH5_IO_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1, OFF_CH5_IO_CTRL, 32'h0000_0005);
        cyc(3);
        apb(0, OFF_PIN_STATE, 32'h0000_0000);
        chk(rd, 32'h0000_0070);
        ch5_count <= 16'hffff;
        cyc(2);
        chk(ch5_cmp_match, 1'b1);
        chk(ch5_pin_a_out, 1'b0);
        final_report();
    end
endmodule
bind tmra_io_ctrl tmra_io_ctrl_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
    .ch3_reg_a_event, .ch4_pin_a_in, .ch5_pin_a_in, .ch4_pin_a_out, .ch4_pin_a_oe, .ch4_cmp_match,
    .ch4_capture, .ch5_cmp_match, .ch5_capture, .irq);
